/* File: design/ppg_gen.sv */
/*
  ppg_gen: one generator: step divider, interval counter and wave-former.
  assumes: countPulse and enable are synchronous one-clock signals.
*/
`timescale 1ns/1ps
`default_nettype none
module ppg_gen
  import ppg_pkg::*;
#(
  parameter int STEP_W = 16,
  parameter int IVL_W  = 24
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // count source
  input wire logic countPulse,
  input wire logic enable,
  // slot registers
  ppg_slot_if.gen  slot
);
  logic [STEP_W-1:0] stepReload;   // divider reload
  logic [STEP_W-1:0] stepCount;    // divider count
  logic [IVL_W-1:0]  ivlReload;    // interval reload
  logic [IVL_W-1:0]  ivlCount;     // interval count
  logic [7:0]        form;         // stored wave-former
  logic              stepRun;      // divider running
  logic              ivlRun;       // interval running
  logic              ivlDone;      // interval hit zero, awaiting divider zero
  logic              pulse;        // output level

  // decode of one count step
  wire startNow  = slot.wrForm & slot.wdata[FORM_START];
  wire tick      = stepRun & enable & countPulse;
  wire stepZero  = tick & (stepCount == STEP_W'(1));                 // divider expires
  wire ivlZero   = stepZero & ivlRun & (ivlCount == IVL_W'(1));      // interval expires
  wire bothZero  = stepZero & ivlDone;                               // both stages at zero
  // divider halts at this expiry; a halting divider must not step the interval
  wire stepHalt  = (bothZero & ~form[FORM_STEP_RELOAD]) |
                   (ivlZero & ~form[FORM_IVL_RELOAD] & ~form[FORM_STEP_RELOAD]);

  assign slot.ivlCount   = 32'(ivlCount);
  assign slot.ivlReload  = 32'(ivlReload);
  assign slot.stepReload = 32'(stepReload);
  assign slot.stepCount  = 32'(stepCount);
  assign slot.form       = form;            // start bit reads as zero
  assign slot.running    = stepRun;
  assign slot.pulse      = pulse;

  // reload registers and wave-former
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stepReload <= '0;
      ivlReload  <= '0;
      form       <= FORM_RESET;
    end else begin
      if (slot.wrStep) stepReload <= slot.wdata[STEP_W-1:0];
      if (slot.wrIvl)  ivlReload  <= slot.wdata[IVL_W-1:0];
      if (slot.wrForm) form       <= slot.wdata[7:0] & FORM_WR_MASK;
    end
  end

  // divider stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stepCount <= '0;
      stepRun   <= 1'b0;
    end else if (startNow) begin
      stepCount <= stepReload;
      stepRun   <= 1'b1;
    end else if (stepZero) begin
      // reload on every expiry; stop running when both stages ended and bit 0 clear
      stepCount <= stepReload;
      stepRun   <= ~stepHalt;
    end else if (tick) begin
      stepCount <= stepCount - STEP_W'(1);
    end
  end

  // interval stage; a write loads both words at once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ivlCount <= '0;
      ivlRun   <= 1'b0;
      ivlDone  <= 1'b0;
    end else if (slot.wrIvl) begin
      ivlCount <= slot.wdata[IVL_W-1:0];
    end else if (startNow) begin
      ivlCount <= ivlReload;
      ivlRun   <= 1'b1;
      ivlDone  <= 1'b0;
    end else if (ivlZero) begin
      ivlCount <= form[FORM_IVL_RELOAD] ? ivlReload : '0;
      ivlRun   <= form[FORM_IVL_RELOAD];
      ivlDone  <= 1'b1;
    end else if (stepZero) begin
      // only an expiry that continues counts as a step
      if (ivlRun && !stepHalt) ivlCount <= ivlCount - IVL_W'(1);
      ivlDone  <= 1'b0;
    end
  end

  // output levels, held between events
  always_ff @(posedge sys_clk) begin
    if (srst) pulse <= 1'b0;
    else if (startNow) pulse <= slot.wdata[FORM_LVL_START];
    else if (ivlZero) pulse <= form[FORM_LVL_IVL];
    else if (bothZero) pulse <= form[FORM_LVL_STEP];
  end

  // step divider only moves on an enabled pulse or a start write
  hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!enable && !startNow) |=> $stable(stepCount)) else $error("divider moved while disabled");
  ivl_load_a: assert property (@(posedge sys_clk) disable iff (srst)
    slot.wrIvl |=> (ivlCount == ivlReload)) else $error("interval load mismatch");
  start_lvl_a: assert property (@(posedge sys_clk) disable iff (srst)
    startNow |=> (pulse == $past(slot.wdata[FORM_LVL_START]) && stepRun)) else $error("start level");
  ivl_lvl_a: assert property (@(posedge sys_clk) disable iff (srst)
    (ivlZero && !startNow) |=> (pulse == $past(form[FORM_LVL_IVL]))) else $error("interval level");
  ivl_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (ivlZero && !form[FORM_IVL_RELOAD] && !startNow) |=> !ivlRun) else $error("interval not stopped");
  step_dec_a: assert property (@(posedge sys_clk) disable iff (srst)
    (tick && !stepZero && !startNow) |=> (stepCount == $past(stepCount) - STEP_W'(1)))
    else $error("divider step");
  ivl_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    (stepZero && ivlRun && !ivlZero && !stepHalt && !startNow && !slot.wrIvl)
    |=> (ivlCount == $past(ivlCount) - IVL_W'(1))) else $error("interval step");
  halt_ivl_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bothZero && !form[FORM_STEP_RELOAD] && !ivlZero && !startNow && !slot.wrIvl)
    |=> $stable(ivlCount)) else $error("interval stepped by halting divider");
  both_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (bothZero && !form[FORM_STEP_RELOAD] && !startNow) |=> !stepRun) else $error("divider not stopped");
  form_bits_a: assert property (@(posedge sys_clk) disable iff (srst)
    (form[FORM_START] == 1'b0 && form[3] == 1'b0 && form[7] == 1'b0)) else $error("form bits");

  start_c: cover property (@(posedge sys_clk) startNow);
  ivl_c:   cover property (@(posedge sys_clk) ivlZero);
  both_c:  cover property (@(posedge sys_clk) bothZero);
endmodule
`default_nettype wire

/* File: design/ppg_pkg.sv */
/*
  ppg_pkg: shared constants for the programmable pulse generator bank.
  assumes: register access is a word-wide alternate-space port inside the processor clock domain.
*/
package ppg_pkg;
  // address map of the bank
  localparam int BANK_BYTES  = 4096;                   // region reserved for the bank
  localparam int SLOT_BYTES  = 32;                     // bytes per generator slot
  localparam int MAX_GENS    = BANK_BYTES / SLOT_BYTES; // 128 generators at most
  localparam logic [7:0] ASI_PRIMARY = 8'h01;          // alternate space codes that select the bank
  localparam logic [7:0] ASI_ALT     = 8'h81;
  // word offsets within a slot
  localparam logic [4:0] OFF_IVL_RELOAD  = 5'h00;
  localparam logic [4:0] OFF_IVL_COUNT   = 5'h04;
  localparam logic [4:0] OFF_STEP_RELOAD = 5'h08;
  localparam logic [4:0] OFF_STEP_COUNT  = 5'h0C;
  localparam logic [4:0] OFF_FORM        = 5'h10;
  // wave-former field positions
  localparam int FORM_STEP_RELOAD = 0;
  localparam int FORM_IVL_RELOAD  = 1;
  localparam int FORM_START       = 2;
  localparam int FORM_LVL_STEP    = 4;
  localparam int FORM_LVL_IVL     = 5;
  localparam int FORM_LVL_START   = 6;
  localparam logic [7:0] FORM_WR_MASK = 8'h73;          // start bit and bit 3 never stored
  localparam logic [7:0] FORM_RESET   = 8'h00;
  // widths allowed for the two stages
  localparam int CNT_MIN_W = 8;
  localparam int CNT_MAX_W = 32;
endpackage

/* File: design/ppg_slot_if.sv */
/*
  ppg_slot_if: write strobes and data from the bank decoder to one generator slot.
  assumes: one instance per generator, driven by the bank top.
*/
`timescale 1ns/1ps
`default_nettype none
interface ppg_slot_if;
  logic        wrIvl;    // interval start value write
  logic        wrStep;   // step divider reload write
  logic        wrForm;   // wave-former write
  logic [31:0] wdata;    // write data
  logic [31:0] ivlCount; // interval count state
  logic [31:0] ivlReload;
  logic [31:0] stepReload;
  logic [31:0] stepCount;
  logic [7:0]  form;
  logic        running;
  logic        pulse;    // generator output level
  modport bank (output wrIvl, wrStep, wrForm, wdata,
                input ivlCount, ivlReload, stepReload, stepCount, form, running, pulse);
  modport gen  (input wrIvl, wrStep, wrForm, wdata,
                output ivlCount, ivlReload, stepReload, stepCount, form, running, pulse);
endinterface
`default_nettype wire

/* File: design/ppg_bank.sv */
/*
  ppg_bank: bank of programmable pulse generators behind the alternate-space port.
  assumes: the processor presents a single-cycle word access with an alternate space code;
  counting pulses and enables arrive per generator in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 4096-byte bank, 32-byte slots, 128 max
// - divider width between 8 and 32
// - divider decrements on each count pulse
// - divider counts only while enable high
// - bit 0 picks divider stop or reload
// - divider expiry steps interval counter once, unless the divider halts
// - interval width between 8 and 32
// - interval write loads reload and count
// - interval count readable, reload optional
// - bit 1 picks interval stop or reload
// - 8-bit wave-former, levels and control
// - start bit reloads both, drives bit 6
// - bit 6 is level at start
// - bit 5 is level at interval zero
// - bit 4 level at next divider zero
// - bit 3 reserved, upper bits undefined
// - slot word offsets 0,4,8,12,16
// - narrow registers sit in low bits
module ppg_bank
  import ppg_pkg::*;
#(
  parameter int NUM_GENS = 4,   // generators fitted
  parameter int STEP_W   = 16,  // divider width
  parameter int IVL_W    = 24   // interval width
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // alternate-space access port
  input  wire logic                accValid,
  input  wire logic                accWrite,
  input  wire logic [7:0]          accAsi,
  input  wire logic [11:0]         accAddr,
  input  wire logic [31:0]         accWdata,
  output logic                     accReady,
  output logic [31:0]              accRdata,
  // count sources
  input  wire logic [NUM_GENS-1:0] countPulse,
  input  wire logic [NUM_GENS-1:0] countEnable,
  // generator outputs
  output logic [NUM_GENS-1:0]      pulseOut
);
  // widths are limited to the documented range
  if (STEP_W < CNT_MIN_W || STEP_W > CNT_MAX_W || IVL_W < CNT_MIN_W || IVL_W > CNT_MAX_W ||
      NUM_GENS < 1 || NUM_GENS > MAX_GENS) begin : g_bad_cfg
    $error("generator bank parameters out of range");
  end

  // address decode of the bank region
  wire       bankSel = accValid & ((accAsi == ASI_PRIMARY) | (accAsi == ASI_ALT));
  wire [6:0] slotIdx = accAddr[11:5];
  wire [4:0] wordOff = {accAddr[4:2], 2'b00};
  wire       slotOk  = 32'(slotIdx) < NUM_GENS;

  ppg_slot_if slots [NUM_GENS] ();
  logic [31:0] rdWord [NUM_GENS];  // per-slot read mux
  logic [NUM_GENS-1:0] genPulse;   // generator levels, registered in each slot

  // one generator per slot
  for (genvar g = 0; g < NUM_GENS; g++) begin : g_gen
    wire hit = bankSel & accWrite & (32'(slotIdx) == g);
    assign slots[g].wrIvl  = hit & (wordOff == OFF_IVL_RELOAD);
    assign slots[g].wrStep = hit & (wordOff == OFF_STEP_RELOAD);
    assign slots[g].wrForm = hit & (wordOff == OFF_FORM);
    assign slots[g].wdata  = accWdata;
    // count register writes are ignored; counts move by counting, start and interval writes
    assign rdWord[g] = (wordOff == OFF_IVL_RELOAD)  ? slots[g].ivlReload  :
                       (wordOff == OFF_IVL_COUNT)   ? slots[g].ivlCount   :
                       (wordOff == OFF_STEP_RELOAD) ? slots[g].stepReload :
                       (wordOff == OFF_STEP_COUNT)  ? slots[g].stepCount  :
                       (wordOff == OFF_FORM)        ? {24'h000000, slots[g].form} : 32'h00000000;
    assign genPulse[g] = slots[g].pulse;
    ppg_gen #(.STEP_W(STEP_W), .IVL_W(IVL_W)) u_gen (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .countPulse (countPulse[g]),
      .enable     (countEnable[g]),
      .slot       (slots[g])
    );
  end

  // read data selection; empty slots read zero
  logic [31:0] next_accRdata;
  always_comb begin
    next_accRdata = 32'h00000000;
    for (int i = 0; i < NUM_GENS; i++) begin
      if (32'(slotIdx) == i) next_accRdata = rdWord[i];
    end
    if (!(bankSel && !accWrite && slotOk)) next_accRdata = 32'h00000000;
  end

  // registered answer, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accReady <= 1'b0;
      accRdata <= 32'h00000000;
      pulseOut <= '0;
    end else begin
      accReady <= bankSel;
      accRdata <= next_accRdata;
      pulseOut <= genPulse;
    end
  end

  ready_a: assert property (@(posedge sys_clk) disable iff (srst)
    bankSel |=> accReady) else $error("access not answered");
  out_a: assert property (@(posedge sys_clk) disable iff (srst)
    1'b1 |=> (pulseOut == $past(genPulse))) else $error("output not registered");
  rd_c: cover property (@(posedge sys_clk) bankSel && !accWrite);
  wr_c: cover property (@(posedge sys_clk) bankSel && accWrite);
endmodule
`default_nettype wire

/* File: verification/tb_ppg_bank.sv */
/*
  tb_ppg_bank: self-checking bench for the pulse generator bank, mostly on slot 0.
  assumes: ppg_pkg and the design files are compiled first; default parameters (4 slots, 16/24-bit stages).
*/
`timescale 1ns/1ps
`default_nettype none
module tb_ppg_bank
  import ppg_pkg::*;
;
  // clock and reset
  logic        sys_clk;
  logic        srst;
  // access port
  logic        accValid;
  logic        accWrite;
  logic [7:0]  accAsi;
  logic [11:0] accAddr;
  logic [31:0] accWdata;
  logic        accReady;
  logic [31:0] accRdata;
  // count sources and outputs
  logic [3:0]  countPulse;
  logic [3:0]  countEnable;
  logic [3:0]  pulseOut;
  // bookkeeping
  int          nMismatch;
  int          compares;
  int          cycles;
  logic [31:0] rdv;
  logic        seen;

  ppg_bank ppg_bank_inst (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .accValid    (accValid),
    .accWrite    (accWrite),
    .accAsi      (accAsi),
    .accAddr     (accAddr),
    .accWdata    (accWdata),
    .accReady    (accReady),
    .accRdata    (accRdata),
    .countPulse  (countPulse),
    .countEnable (countEnable),
    .pulseOut    (pulseOut)
  );

  // free-running 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // hang guard: whole run needs a few hundred cycles
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      nMismatch = nMismatch + 1;
      $display("wrong value at %0t: run timed out", $time);
      summarize();
    end
  end

  // word result comparison
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares = compares + 1;
    if (got !== exp) begin
      nMismatch = nMismatch + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // single-bit result comparison
  task automatic chk1(input logic got, input logic exp, input string what);
    compares = compares + 1;
    if (got !== exp) begin
      nMismatch = nMismatch + 1;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // one access: pulse valid for one cycle, then watch a short window for the answer
  task automatic acc(input logic wr, input logic [7:0] asi, input logic [11:0] a, input logic [31:0] d);
    seen = 1'b0;
    rdv = 32'h0000_0000;
    accValid = 1'b1;
    accWrite = wr;
    accAsi = asi;
    accAddr = a;
    accWdata = d;
    @(negedge sys_clk);
    accValid = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (accReady === 1'b1 && seen === 1'b0) begin
        seen = 1'b1;
        rdv = accRdata;
      end
      @(negedge sys_clk);
    end
  endtask

  // register write in the primary space
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, ASI_PRIMARY, a, d);
    chk1(seen, 1'b1, "write answered");
  endtask

  // register read with expected word
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [7:0] asi = ASI_PRIMARY);
    acc(1'b0, asi, a, 32'h0000_0000);
    chk1(seen, 1'b1, "read answered");
    chk32(rdv, e, "read data");
  endtask

  // n count pulses on slot 0, one every other cycle
  task automatic tick(input int n);
    repeat (n) begin
      countPulse[0] = 1'b1;
      @(negedge sys_clk);
      countPulse[0] = 1'b0;
      @(negedge sys_clk);
    end
  endtask

  // output level of slot 0 after the registered stages settle
  task automatic lvl(input logic e);
    repeat (3) @(negedge sys_clk);
    chk1(pulseOut[0], e, "slot 0 output");
  endtask

  // single exit point
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence; inputs move on falling edges only
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    accValid = 1'b0;
    accWrite = 1'b0;
    accAsi = 8'h00;
    accAddr = 12'h000;
    accWdata = 32'h0000_0000;
    countPulse = 4'h0;
    countEnable = 4'h0;
    nMismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    // reset state of every word in slot 0
    for (int w = 0; w < 5; w++) rd(12'(4 * w), 32'h0000_0000);
    chk32({28'h0, pulseOut}, 32'h0000_0000, "outputs after reset");
    $display("test reset done");
    // map, widths and refused accesses
    wr({7'd0, OFF_IVL_RELOAD}, 32'h0000_0002);
    rd({7'd0, OFF_IVL_RELOAD}, 32'h0000_0002);
    rd({7'd0, OFF_IVL_COUNT}, 32'h0000_0002);
    wr({7'd0, OFF_STEP_RELOAD}, 32'hFFFF_0002);
    rd({7'd0, OFF_STEP_RELOAD}, 32'h0000_0002);
    wr({7'd0, OFF_STEP_COUNT}, 32'h0000_0009);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0000);
    wr({7'd0, OFF_FORM}, 32'hFFFF_FFFB);
    rd({7'd0, OFF_FORM}, 32'h0000_0073);
    wr({7'd1, OFF_IVL_RELOAD}, 32'h0000_0005);
    rd({7'd1, OFF_IVL_COUNT}, 32'h0000_0005, ASI_ALT);
    acc(1'b1, 8'h02, {7'd1, OFF_IVL_RELOAD}, 32'h0000_0007);
    chk1(seen, 1'b0, "foreign space write");
    rd({7'd1, OFF_IVL_RELOAD}, 32'h0000_0005);
    rd({7'd5, OFF_FORM}, 32'h0000_0000);
    $display("test map done");
    // free-running mode: start high, interval end low, next divider end high
    wr({7'd0, OFF_FORM}, 32'h0000_0057);
    lvl(1'b1);
    tick(2);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0002);
    countEnable[0] = 1'b1;
    tick(1);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0001);
    wr({7'd0, OFF_FORM}, 32'h0000_0057);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0002);
    rd({7'd0, OFF_FORM}, 32'h0000_0053);
    tick(2);
    rd({7'd0, OFF_IVL_COUNT}, 32'h0000_0001);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0002);
    lvl(1'b1);
    tick(2);
    lvl(1'b0);
    rd({7'd0, OFF_IVL_COUNT}, 32'h0000_0002);
    tick(2);
    lvl(1'b1);
    $display("test repeat done");
    // one-shot mode: both stages stop at interval end
    wr({7'd0, OFF_FORM}, 32'h0000_0024);
    lvl(1'b0);
    tick(4);
    lvl(1'b1);
    tick(6);
    lvl(1'b1);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0002);
    rd({7'd0, OFF_IVL_COUNT}, 32'h0000_0000);
    $display("test one-shot done");
    // halt mode: interval reloads, divider stops at the expiry after interval end
    wr({7'd0, OFF_FORM}, 32'h0000_0026);
    lvl(1'b0);
    tick(4);
    lvl(1'b1);
    tick(2);
    lvl(1'b0);
    tick(2);
    rd({7'd0, OFF_STEP_COUNT}, 32'h0000_0002);
    rd({7'd0, OFF_IVL_COUNT}, 32'h0000_0002);
    $display("test halt done");
    summarize();
  end
endmodule
`default_nettype wire
